//--- rtl/touch_seq_defs.svh
// Named offsets, reset values, field ranges and timing for the touch block.
// Assumes inclusion by bare name; holds definitions only.
`ifndef TOUCH_SEQ_DEFS_SVH
`define TOUCH_SEQ_DEFS_SVH
// Core clock period and the common timing tick
`define CLK_PERIOD_NS 40
`define TICK_NS 5000
`define TICK_CYCLES ((`TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// 35 ms step shared by press time, repeat interval and cycle time
`define STEP_MS 35
`define STEP_TICKS (`STEP_MS * 1000000 / `TICK_NS)
// Shortest single sample, doubled per code step
`define SAMP_BASE_US 320
`define SAMP_BASE_TICKS (`SAMP_BASE_US * 1000 / `TICK_NS)
// Register offsets
`define ADDR_PRESS 8'h23
`define ADDR_AVGS 8'h24
`define ADDR_CAL 8'h26
`define ADDR_IRQEN 8'h27
`define ADDR_RPTEN 8'h28
// Reset values at field width
`define RST_PRESS 4'h7
`define RST_AVGS 7'h39
`define RST_CAL 3'h0
`define RST_IRQEN 3'h7
`define RST_RPTEN 3'h7
// Field ranges
`define PRESS_RANGE 3:0
`define AVGS_RANGE 6:0
`define AVG_RANGE 6:4
`define SAMP_RANGE 3:2
`define CYC_RANGE 1:0
`define INPUT_RANGE 2:0
// Calibration value limits
`define CAL_MAX 10'h3ff
`define CAL_MIN 10'h000
// Counter widths
`define HOLD_W 17
`define PER_W 18
`endif

//--- rtl/touch_seq_pkg.sv
// Types shared by the touch sequencing block.
// Assumes the defs header is on the include path.
`include "touch_seq_defs.svh"
package touch_seq_pkg;
    // Sensing cycle phase
    typedef enum logic [0:0] {
        SEQ_IDLE = 1'b0,
        SEQ_SAMPLE = 1'b1
    } seq_state_e;
    // Touch duration counter, counted in ticks
    typedef logic [`HOLD_W-1:0] hold_t;
    // Sensing period counter
    typedef logic [`PER_W-1:0] period_t;
endpackage

//--- rtl/touch_sense_cycle_interrupt_control.sv
// Sensing cycle, calibration request and touch alert logic for three inputs.
// Assumes a core clock of 25 MHz and a front end on its own clock that
// reports calibration results; touch levels arrive asynchronously.
// Overview of operation
// - With auto repeat on, touch beyond press time is press-and-hold
// - Press time is (code+1) times 35 ms
// - Samples per measurement are two to the code
// - Sample one input fully, average, then next
// - Sample time is 320 us doubled per code
// - Cycle period (code+1)x35 ms, idle after sampling
// - Period stretches until all samples are taken
// - Writing one forces calibration of that input
// - Store calibration value; clear bit on success
// - Newly enabled inputs request calibration themselves
// - Noise or limit value fails; sets failure flag
// - Writing zero cancels a pending calibration
// - Per-input enable gates the active-low alert
// - Without repeat: alert on touch and release
// - Plain touch with repeat: touch and release
// - Press-and-hold alerts at the repeat interval
// - Repeat interval is (code+1) times 35 ms
// - Release alert suppressed when control bit set
`timescale 1ns/10ps
`include "touch_seq_defs.svh"
module touch_sense_cycle_interrupt_control
    import touch_seq_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_sense_clk,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic [2:0] i_input_enable,
    input wire logic i_deep_sleep,
    input wire logic i_suppress_release_irq,
    input wire logic [3:0] i_repeat_interval,
    input wire logic i_alert_ack,
    input wire logic i_touch_input_one,
    input wire logic i_touch_input_two,
    input wire logic i_touch_input_three,
    input wire logic [7:0] i_sample_value,
    input wire logic i_cal_done,
    input wire logic [1:0] i_cal_channel,
    input wire logic [9:0] i_cal_value,
    input wire logic i_cal_noise,
    output logic o_alert_n,
    output logic o_sensing_active,
    output logic o_meas_valid,
    output logic [1:0] o_meas_channel,
    output logic [7:0] o_meas_result,
    output logic [2:0] o_cal_request,
    output logic [29:0] o_input_calibration_value,
    output logic o_analog_recal_failure_flag
);
    // Refuse tick lengths the 16-bit divider cannot hold
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_chk
        $error("TICK_CYCLES out of range");
    end

    // All checks run on the core clock and rest during reset
    default clocking @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);

    logic [15:0] tick_cnt; // Core clock divider
    logic tick; // One-cycle common timing tick
    logic [3:0] press_reg; // Minimum press time code
    logic [6:0] avgs_reg; // Averaging, sample and cycle time
    logic [2:0] cal_req_reg; // Calibration request bits
    logic [2:0] cal_next;
    logic [2:0] fail_reg; // Inputs whose last calibration failed
    logic [2:0] fail_next;
    logic [2:0] irq_en_reg; // Alert enable per input
    logic [2:0] rpt_en_reg; // Auto repeat enable per input
    logic [2:0] eff_en; // Enabled and awake
    logic [2:0] en_prev; // Last cycle's effective enable
    logic [2:0] newly; // Inputs enabled this cycle
    logic wr_cal; // Host write to calibration register
    // Touch synchronisers and filtered level
    logic [2:0] t_s1, t_s2, t_s3, touch_q;
    logic [2:0] touch_rise, touch_fall;
    // Per-input duration state
    hold_t hold_cnt [3];
    logic [2:0] phold; // Press-and-hold classified
    logic [2:0] ev_reg; // Alert events, already gated
    hold_t press_lim, rpt_lim;
    // Sequencer
    seq_state_e state;
    period_t period_cnt, cycle_ticks;
    logic [9:0] samp_cnt, per_sample_duration;
    logic [2:0] sample_average_count;
    logic [7:0] nsamp;
    logic [1:0] chan;
    logic [14:0] acc, acc_sum;
    logic samp_end, last_samp;
    // Link-side capture and crossing
    logic lk_tog;
    logic [1:0] lk_chan;
    logic [9:0] lk_val;
    logic lk_noise;
    logic [2:0] lk_req_s1;
    logic g_s1, g_s2, g_s3;
    logic cal_evt, cal_ok;

    // Common tick divider
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tick_cnt <= 16'h0000;
        end else if (tick) begin
            tick_cnt <= 16'h0000;
        end else begin
            tick_cnt <= tick_cnt + 16'h0001;
        end
    end
    assign tick = (tick_cnt == 16'(TICK_CYCLES - 1));

    // Register writes; unused bits are dropped
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            press_reg <= `RST_PRESS;
            avgs_reg <= `RST_AVGS;
            irq_en_reg <= `RST_IRQEN;
            rpt_en_reg <= `RST_RPTEN;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                `ADDR_PRESS: press_reg <= i_reg_wdata[`PRESS_RANGE];
                `ADDR_AVGS: avgs_reg <= i_reg_wdata[`AVGS_RANGE];
                `ADDR_IRQEN: irq_en_reg <= i_reg_wdata[`INPUT_RANGE];
                `ADDR_RPTEN: rpt_en_reg <= i_reg_wdata[`INPUT_RANGE];
                default: ; // Other offsets ignored
            endcase
        end
    end

    // Registered read data, zero above each field
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 8'h00;
        end else begin
            case (i_reg_addr)
                `ADDR_PRESS: o_reg_rdata <= {4'h0, press_reg};
                `ADDR_AVGS: o_reg_rdata <= {1'b0, avgs_reg};
                `ADDR_CAL: o_reg_rdata <= {5'h00, cal_req_reg};
                `ADDR_IRQEN: o_reg_rdata <= {5'h00, irq_en_reg};
                `ADDR_RPTEN: o_reg_rdata <= {5'h00, rpt_en_reg};
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // Field decode: timers in ticks
    assign sample_average_count = avgs_reg[`AVG_RANGE];
    assign per_sample_duration =
        10'(`SAMP_BASE_TICKS) << avgs_reg[`SAMP_RANGE];
    assign cycle_ticks =
        period_t'((32'(avgs_reg[`CYC_RANGE]) + 32'd1) * `STEP_TICKS);
    assign press_lim = hold_t'((32'(press_reg) + 32'd1) * `STEP_TICKS);
    assign rpt_lim =
        hold_t'((32'(i_repeat_interval) + 32'd1) * `STEP_TICKS);

    // Sample accumulation helpers
    assign samp_end = (samp_cnt == per_sample_duration - 10'd1);
    assign last_samp =
        (nsamp == 8'((9'd1 << sample_average_count) - 9'd1));
    assign acc_sum = acc + {7'h00, i_sample_value};
    assign eff_en = i_input_enable & {3{~i_deep_sleep}};

    // Sensing cycle sequencer
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= SEQ_IDLE;
            period_cnt <= '0;
            samp_cnt <= 10'h000;
            nsamp <= 8'h00;
            chan <= 2'h0;
            acc <= 15'h0000;
            o_meas_valid <= 1'b0;
            o_meas_channel <= 2'h0;
            o_meas_result <= 8'h00;
            o_sensing_active <= 1'b0;
        end else begin
            o_meas_valid <= 1'b0;
            if (tick) begin
                // Period counts until reached, then holds
                if (period_cnt < cycle_ticks) begin
                    period_cnt <= period_cnt + 1'b1;
                end
                case (state)
                    SEQ_IDLE: begin
                        // New period only once the old one ran out
                        if (period_cnt >= cycle_ticks && |eff_en) begin
                            state <= SEQ_SAMPLE;
                            period_cnt <= '0;
                            chan <= 2'h0;
                            samp_cnt <= 10'h000;
                            nsamp <= 8'h00;
                            acc <= 15'h0000;
                            o_sensing_active <= 1'b1;
                        end
                    end
                    SEQ_SAMPLE: begin
                        // Count one sample's duration
                        if (eff_en[chan] && !samp_end) begin
                            samp_cnt <= samp_cnt + 10'd1;
                        end
                        // Samples of one input back to back
                        if (eff_en[chan] && samp_end) begin
                            samp_cnt <= 10'h000;
                            acc <= acc_sum;
                            nsamp <= nsamp + 8'd1;
                        end
                        // Skip disabled inputs or finish with the average
                        if (!eff_en[chan] || (samp_end && last_samp)) begin
                            nsamp <= 8'h00;
                            acc <= 15'h0000;
                            if (chan == 2'h2) begin
                                state <= SEQ_IDLE;
                                o_sensing_active <= 1'b0;
                            end else begin
                                chan <= chan + 2'h1;
                            end
                        end
                        // Averaged result update
                        if (eff_en[chan] && samp_end && last_samp) begin
                            o_meas_valid <= 1'b1;
                            o_meas_channel <= chan;
                            o_meas_result <=
                                8'(acc_sum >> sample_average_count);
                        end
                    end
                    default: state <= SEQ_IDLE;
                endcase
            end
        end
    end

    // Link side: capture result and flag it by toggle
    always_ff @(posedge i_sense_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            lk_tog <= 1'b0;
            lk_chan <= 2'h0;
            lk_val <= 10'h000;
            lk_noise <= 1'b0;
        end else if (i_cal_done) begin
            lk_tog <= ~lk_tog;
            lk_chan <= i_cal_channel;
            lk_val <= i_cal_value;
            lk_noise <= i_cal_noise;
        end
    end

    // Link side: calibration requests brought over by two flops
    always_ff @(posedge i_sense_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            lk_req_s1 <= 3'h0;
            o_cal_request <= 3'h0;
        end else begin
            lk_req_s1 <= cal_req_reg;
            o_cal_request <= lk_req_s1;
        end
    end

    // Core side: toggle and touch synchronisers
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            {g_s1, g_s2, g_s3} <= 3'h0;
            t_s1 <= 3'h0;
            t_s2 <= 3'h0;
            t_s3 <= 3'h0;
            touch_q <= 3'h0;
        end else begin
            {g_s1, g_s2, g_s3} <= {lk_tog, g_s1, g_s2};
            t_s1 <= {i_touch_input_three, i_touch_input_two,
                     i_touch_input_one};
            t_s2 <= t_s1;
            t_s3 <= t_s2;
            touch_q <= (touch_q | touch_rise) & ~touch_fall;
        end
    end
    // A change counts once the last two stages agree
    assign touch_rise = t_s2 & t_s3 & ~touch_q;
    assign touch_fall = ~t_s2 & ~t_s3 & touch_q;
    assign cal_evt = g_s2 ^ g_s3;
    // Noise or a limit value is a failure
    assign cal_ok = !lk_noise && lk_val != `CAL_MAX && lk_val != `CAL_MIN;
    assign wr_cal = i_reg_wr && (i_reg_addr == `ADDR_CAL);
    assign newly = eff_en & ~en_prev;

    // Calibration request and failure next state
    always_comb begin
        cal_next = cal_req_reg;
        fail_next = fail_reg;
        if (wr_cal) begin
            // One forces, zero cancels
            cal_next = i_reg_wdata[`INPUT_RANGE];
        end
        if (cal_evt && lk_chan != 2'h3) begin
            if (cal_ok) begin
                cal_next[lk_chan] = 1'b0;
                fail_next[lk_chan] = 1'b0;
            end else begin
                fail_next[lk_chan] = 1'b1;
            end
        end
        // Newly enabled inputs set their bit; set wins
        cal_next = cal_next | newly;
    end

    // Calibration registers, stored values and failure flag
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cal_req_reg <= `RST_CAL;
            fail_reg <= 3'h0;
            en_prev <= 3'h0;
            o_input_calibration_value <= 30'h00000000;
            o_analog_recal_failure_flag <= 1'b0;
        end else begin
            cal_req_reg <= cal_next;
            fail_reg <= fail_next;
            en_prev <= eff_en;
            // Result stored whether or not it passed
            if (cal_evt && lk_chan != 2'h3) begin
                o_input_calibration_value[lk_chan * 10 +: 10] <= lk_val;
            end
            // Flag any bit left set by a failure
            o_analog_recal_failure_flag <= |(fail_next & cal_next);
        end
    end

    // Per-input touch timing and alert events
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            phold <= 3'h0;
            ev_reg <= 3'h0;
            for (int k = 0; k < 3; k++) begin
                hold_cnt[k] <= '0;
            end
        end else begin
            for (int k = 0; k < 3; k++) begin
                ev_reg[k] <= 1'b0;
                if (touch_rise[k]) begin
                    // Restart duration; alert on touch
                    hold_cnt[k] <= '0;
                    phold[k] <= 1'b0;
                    ev_reg[k] <= irq_en_reg[k];
                end else if (touch_fall[k]) begin
                    // Release alert unless suppressed
                    phold[k] <= 1'b0;
                    ev_reg[k] <= irq_en_reg[k] & ~i_suppress_release_irq;
                end else if (touch_q[k] && tick) begin
                    if (!phold[k]) begin
                        // With auto repeat on, longer than press time is a hold
                        if (rpt_en_reg[k] && hold_cnt[k] >= press_lim) begin
                            phold[k] <= 1'b1;
                            hold_cnt[k] <= '0;
                        end else if (hold_cnt[k] < press_lim) begin
                            hold_cnt[k] <= hold_cnt[k] + 1'b1;
                        end
                    end else if (!rpt_en_reg[k]) begin
                        phold[k] <= 1'b0; // Repeat dropped mid-hold
                    end else if (hold_cnt[k] + 1'b1 >= rpt_lim) begin
                        // Repeat alert every interval
                        hold_cnt[k] <= '0;
                        ev_reg[k] <= irq_en_reg[k];
                    end else begin
                        hold_cnt[k] <= hold_cnt[k] + 1'b1;
                    end
                end
            end
        end
    end

    // Active-low alert, held until acknowledged; event wins
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_alert_n <= 1'b1;
        end else if (|ev_reg) begin
            o_alert_n <= 1'b0;
        end else if (i_alert_ack) begin
            o_alert_n <= 1'b1;
        end
    end

    a_touch_alert: assert property (
        touch_rise[0] && irq_en_reg[0] |=> ##1 !o_alert_n)
        else $error("touch did not assert alert");
    a_masked_touch: assert property (
        touch_rise[1] && !irq_en_reg[1] |=> !ev_reg[1])
        else $error("masked touch raised event");
    a_release_quiet: assert property (
        touch_fall[0] && i_suppress_release_irq |=> !ev_reg[0])
        else $error("suppressed release raised event");
    a_norpt_nohold: assert property (
        !rpt_en_reg[2] && !phold[2] |=> !phold[2])
        else $error("hold without auto repeat");
    a_cal_newly: assert property (
        newly[0] |=> cal_req_reg[0])
        else $error("newly enabled input not requested");
    a_cal_write: assert property (
        wr_cal && !cal_evt && newly == 3'h0
        |=> cal_req_reg == $past(i_reg_wdata[2:0]))
        else $error("calibration write not stored");
    a_cal_clears: assert property (
        cal_evt && cal_ok && lk_chan == 2'h0 && !wr_cal && !newly[0]
        |=> !cal_req_reg[0])
        else $error("good calibration left bit set");
    a_cal_fail: assert property (
        cal_evt && !cal_ok && lk_chan == 2'h0 && !wr_cal
        |=> ##1 o_analog_recal_failure_flag)
        else $error("failure flag not set");
    a_meas_sample: assert property (
        o_meas_valid |-> $past(state) == SEQ_SAMPLE && $past(last_samp))
        else $error("result outside sampling");
    a_rsvd_zero: assert property (
        !o_reg_rdata[7])
        else $error("reserved bit reads one");
endmodule

//--- bench/cal_front_end_model.sv
// Front-end model that reports calibration results on the link clock.
// Assumes the bench calls report and spaces the calls well apart.
`timescale 1ns/10ps
module cal_front_end_model (
    input wire logic i_sense_clk,
    output logic o_cal_done,
    output logic [1:0] o_cal_channel,
    output logic [9:0] o_cal_value,
    output logic o_cal_noise
);
    // Idle values at time zero
    initial begin
        o_cal_done = 1'b0;
        o_cal_channel = 2'h3;
        o_cal_value = 10'h2aa;
        o_cal_noise = 1'b0;
    end
    // One result pulse; data is inverted afterwards so it never lingers
    task automatic report(input logic [1:0] ch, input logic [9:0] val,
                          input logic nz);
        @(posedge i_sense_clk);
        o_cal_done <= 1'b1;
        o_cal_channel <= ch;
        o_cal_value <= val;
        o_cal_noise <= nz;
        @(posedge i_sense_clk);
        o_cal_done <= 1'b0;
        o_cal_channel <= ~ch;
        o_cal_value <= ~val;
        o_cal_noise <= ~nz;
    endtask
endmodule

//--- bench/touch_sense_cycle_interrupt_control_tb.sv
// Self-checking bench for the touch sequencing and alert block.
// Assumes a one-cycle tick, so 35 ms is 7000 core cycles.
`timescale 1ns/10ps
module touch_sense_cycle_interrupt_control_tb;
    import touch_seq_pkg::*;
    // Stimulus and observation signals
    logic clock = 1'b0, sense_clk = 1'b0, rst = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rv;
    logic wr_en = 1'b0, ack = 1'b0, supp = 1'b0;
    logic [2:0] touch = 3'h0;
    logic cal_done, cal_noise, alert_n, flag;
    logic [1:0] cal_ch;
    logic [9:0] cal_val;
    logic [2:0] cal_req;
    logic [29:0] cal_store;
    logic [2:0] en = 3'h7; // Per-input enable
    logic sleep = 1'b0; // Deep sleep request
    logic sens, mvalid; // Sequencer phase and result strobe
    logic [1:0] mch;
    logic [7:0] mres;
    int bad_count = 0, total_checks = 0;
    // Clocks: core 40 ns, link 48 ns with an offset
    always #20 clock = ~clock;
    initial #7 forever #24 sense_clk = ~sense_clk;
    touch_sense_cycle_interrupt_control #(.TICK_CYCLES(1)) i_dut (
        .i_clock(clock), .i_sys_rst(rst), .i_sense_clk(sense_clk),
        .i_reg_addr(addr), .i_reg_wr(wr_en), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .i_input_enable(en), .i_deep_sleep(sleep),
        .i_suppress_release_irq(supp), .i_repeat_interval(4'h0),
        .i_alert_ack(ack), .i_touch_input_one(touch[0]),
        .i_touch_input_two(touch[1]), .i_touch_input_three(touch[2]),
        .i_sample_value(8'h40), .i_cal_done(cal_done),
        .i_cal_channel(cal_ch), .i_cal_value(cal_val),
        .i_cal_noise(cal_noise), .o_alert_n(alert_n),
        .o_sensing_active(sens), .o_meas_valid(mvalid),
        .o_meas_channel(mch), .o_meas_result(mres), .o_cal_request(cal_req),
        .o_input_calibration_value(cal_store),
        .o_analog_recal_failure_flag(flag));
    cal_front_end_model i_model (
        .i_sense_clk(sense_clk), .o_cal_done(cal_done),
        .o_cal_channel(cal_ch), .o_cal_value(cal_val),
        .o_cal_noise(cal_noise));
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One register write
    task automatic wr(input logic [7:0] a, d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    // One register read, data taken two cycles after the address
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input string nm);
        @(posedge clock);
        addr <= a;
        repeat (2) @(posedge clock);
        chk(nm, {24'h0, e}, {24'h0, rdata});
    endtask
    // Watch for a low alert over a bounded span
    task automatic alert_in(input int lim, input logic e, input string nm);
        logic seen;
        seen = 1'b0;
        repeat (lim) begin
            @(posedge clock);
            if (alert_n === 1'b0) seen = 1'b1;
        end
        chk(nm, {31'h0, e}, {31'h0, seen});
    endtask
    // Host clears the alert
    task automatic clear_alert;
        @(posedge clock);
        ack <= 1'b1;
        @(posedge clock);
        ack <= 1'b0;
        @(posedge clock);
    endtask
    // Reset values, unused bits and an unmapped offset
    task automatic t_regs;
        rd(8'h23, 8'h07, "press_hold_time_config");
        rd(8'h24, 8'h39, "averaging_sampling_config");
        rd(8'h26, 8'h07, "calibration_request_status");
        rd(8'h27, 8'h07, "touch_interrupt_enable");
        rd(8'h28, 8'h07, "auto_repeat_enable");
        wr(8'h24, 8'hff);
        rd(8'h24, 8'h7f, "averaging unused bit");
        wr(8'h23, 8'hff);
        rd(8'h23, 8'h0f, "press unused bits");
        wr(8'h25, 8'hff);
        rd(8'h25, 8'h00, "unmapped offset");
        wr(8'h24, 8'h39);
        wr(8'h23, 8'h00);
    endtask
    // Sensing cycle: 2 samples of 320 us per input, 35 ms period
    task automatic t_seq;
        int n, v;
        logic [1:0] mc;
        logic [7:0] mr;
        wr(8'h24, 8'h10);
        n = 0;
        while (sens !== 1'b1 && n < 7200) begin
            @(posedge clock);
            n++;
        end
        chk("period start", 32'h1, {31'h0, sens});
        // First high cycle already seen; 3 inputs x 2 samples x 64 ticks
        n = 1;
        v = 0;
        repeat (420) begin
            @(posedge clock);
            if (sens === 1'b1) n++;
            if (mvalid === 1'b1) begin
                v++;
                mc = mch;
                mr = mres;
            end
        end
        chk("sampling span", 3 * 2 * 64, n);
        chk("result count", 3, v);
        chk("last channel", 32'h2, {30'h0, mc});
        chk("average", 32'h40, {24'h0, mr});
    endtask
    // Results from the front end: success, noise, limit value
    task automatic t_cal;
        i_model.report(2'h0, 10'h100, 1'b0);
        repeat (30) @(posedge clock);
        i_model.report(2'h1, 10'h200, 1'b1);
        repeat (30) @(posedge clock);
        i_model.report(2'h2, 10'h3ff, 1'b0);
        repeat (30) @(posedge clock);
        chk("failure flag", 32'h1, {31'h0, flag});
        rd(8'h26, 8'h06, "bits after results");
        chk("stored value", 32'h100, {22'h0, cal_store[9:0]});
        chk("noisy value", 32'h200, {22'h0, cal_store[19:10]});
        wr(8'h26, 8'h00);
        rd(8'h26, 8'h00, "cancel by zero");
        wr(8'h26, 8'h01);
        rd(8'h26, 8'h01, "forced request");
        i_model.report(2'h0, 10'h000, 1'b0);
        repeat (30) @(posedge clock);
        rd(8'h26, 8'h01, "minimum value fails");
        i_model.report(2'h0, 10'h155, 1'b0);
        repeat (30) @(posedge clock);
        rd(8'h26, 8'h00, "success clears");
        chk("link side bits", 32'h0, {29'h0, cal_req});
        chk("flag cleared", 32'h0, {31'h0, flag});
        // Leaving deep sleep and a fresh enable both request calibration
        sleep <= 1'b1;
        repeat (3) @(posedge clock);
        sleep <= 1'b0;
        rd(8'h26, 8'h07, "wake requests");
        wr(8'h26, 8'h00);
        en <= 3'h5;
        repeat (3) @(posedge clock);
        en <= 3'h7;
        rd(8'h26, 8'h02, "enable requests");
    endtask
    // Touch and release without repeat, then a gated input
    task automatic t_touch;
        wr(8'h28, 8'h00);
        touch[2] <= 1'b1;
        alert_in(12, 1'b1, "touch alert");
        clear_alert();
        alert_in(300, 1'b0, "no repeat while held");
        touch[2] <= 1'b0;
        alert_in(12, 1'b1, "release alert");
        clear_alert();
        wr(8'h27, 8'h05);
        touch[1] <= 1'b1;
        alert_in(30, 1'b0, "gated touch");
        touch[1] <= 1'b0;
        alert_in(30, 1'b0, "gated release");
        wr(8'h27, 8'h07);
    endtask
    // Repeat on: plain touch, then press-and-hold with repeat alerts
    task automatic t_hold;
        wr(8'h28, 8'h07);
        touch[0] <= 1'b1;
        alert_in(12, 1'b1, "plain touch alert");
        clear_alert();
        touch[0] <= 1'b0;
        alert_in(12, 1'b1, "plain release alert");
        clear_alert();
        touch[0] <= 1'b1;
        alert_in(12, 1'b1, "hold touch alert");
        clear_alert();
        alert_in(13900, 1'b0, "quiet before repeat");
        alert_in(300, 1'b1, "repeat alert");
        clear_alert();
        supp <= 1'b1;
        touch[0] <= 1'b0;
        alert_in(30, 1'b0, "suppressed release");
        supp <= 1'b0;
    endtask
    // Counts, verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_seq();
        t_cal();
        t_touch();
        t_hold();
        test_done();
    end
    // Watchdog over about three times the expected run
    initial begin
        #(60000 * 40);
        bad_count++;
        test_done();
    end
endmodule
